/* rtl/cpcr_top.sv */
// configuration pin control, readback engine and ahb-lite register slave
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cpcr_defs.svh"

// Functional notes
// - request low in configuration tristates all I/O
// - option keeps tristate role after configuration
// - falling request starts readback at frame zero
// - serial output carries readback or test data
// - drive error flag low on init errors
// - same output is processor port interrupt
// - latch mode pins on init rising edge
// - mode pin pull-ups, then user I/O
// - disable boundary scan after configuration unless used
// - release test pins as user I/O
// - ready output means another byte accepted
// - selected read returns ready on bit seven
// - master parallel drives ready pin as strobe
// - pll clock pins pulled up, then user
// - init held low while clearing, waits input
// - program low restarts configuration, resets scan
// - done released when complete, low delays start
module cpcr_top #(
    parameter int CLEAR_CYCLES = `CPCR_CLEAR_CYCLES, // memory clear time
    parameter int BIT_DIV      = `CPCR_BIT_DIV,      // cycles per serial bit
    parameter int RB_WORDS     = `CPCR_RB_WORDS,     // frames per readback
    parameter int ADDR_W       = 16                  // frame address width
) (
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 srst_in,
    // ahb-lite slave
    input  wire logic                 hsel_in,
    input  wire logic [31:0]          haddr_in,
    input  wire logic [1:0]           htrans_in,
    input  wire logic                 hwrite_in,
    input  wire logic [2:0]           hsize_in,
    input  wire logic [31:0]          hwdata_in,
    input  wire logic                 hready_in,
    output logic      [31:0]          hrdata_out,
    output logic                      hreadyout_out,
    output logic                      hresp_out,
    // configuration handshake pins, open-drain split
    input  wire logic                 program_restart_n_in,
    input  wire logic                 init_pin_in,
    output logic                      init_out,
    output logic                      init_oe_n_out,
    input  wire logic                 done_pin_in,
    output logic                      done_out,
    output logic                      done_oe_n_out,
    input  wire logic [3:0]           mode_pins_in,
    // readback request and shared serial output
    input  wire logic                 readback_req_n_in,
    input  wire logic                 tdo_in,
    output logic                      serial_out,
    output logic [ADDR_W-1:0]         rb_frame_addr_out,
    input  wire logic [31:0]          rb_word_in,
    // asynchronous peripheral and master parallel pins
    input  wire cpcr_pkg::cpcr_periph_t periph_in,
    output logic                      ready_out,
    output logic                      d7_out,
    output logic                      d7_oe_n_out,
    // core-side status
    input  wire logic                 core_loaded_in,
    input  wire logic                 core_busy_in,
    input  wire logic                 core_init_err_in,
    input  wire logic                 pport_irq_req_in,
    // error flag, shared with processor port interrupt
    output logic                      processor_port_irq_n_out,
    // pin role controls
    output logic                      global_io_tristate_out,
    output logic                      bscan_enable_out,
    output logic                      bscan_reset_out,
    output logic                      mode_pullup_en_out,
    output logic                      jtag_pullup_en_out,
    output logic                      pll_pullup_en_out,
    output logic                      mode_pins_user_out,
    output logic                      jtag_pins_user_out,
    output logic [7:0]                pll_clock_inputs_user_out,
    output logic [3:0]                cfg_mode_out
);
    import cpcr_pkg::*;

    // refuse parameter values the counters cannot serve
    initial begin
        if (CLEAR_CYCLES < 1 || BIT_DIV < 2 || RB_WORDS < 1 ||
            ADDR_W < 1 || ADDR_W > 16 || RB_WORDS > (1 << ADDR_W)) begin
            $error("cpcr_top: unsupported parameter value");
        end
    end

    localparam int CW = $clog2(CLEAR_CYCLES + 1);
    localparam int DW = $clog2(BIT_DIV);

    cpcr_state_t      state_reg;        // configuration sequence
    cpcr_ctrl_t       ctrl_reg;         // bitstream options
    logic [CW-1:0]    clr_cnt_reg;      // memory clear timer
    logic [DW-1:0]    div_cnt_reg;      // bit rate divider
    logic             tick_reg;         // one-cycle bit enable
    logic             init_q_reg;       // previous init pin level
    logic             rq_s1_reg;        // request sync stage one
    logic             rq_s2_reg;        // request sync stage two
    logic             rq_s3_reg;        // delayed copy for edge
    logic             rb_busy_reg;      // readback in progress
    logic [4:0]       bit_cnt_reg;      // bit within the word
    logic [31:0]      shift_reg;        // word being shifted out
    logic             word_live_reg;    // shift_reg holds a word
    logic             err_reg;          // sticky init error
    logic             addr_ph_reg;      // ahb data phase pending
    logic             wr_ph_reg;        // pending phase is a write
    logic [`CPCR_ADDR_MSB:0] addr_reg;  // pending register address
    logic             pport_mode;       // processor port mode chosen
    logic             rq_fall;          // request falling edge
    logic             ahb_go;           // valid ahb address phase

    assign pport_mode = (cfg_mode_out == `CPCR_MODE_PPORT);
    assign rq_fall    = rq_s3_reg & ~rq_s2_reg;
    assign ahb_go     = hsel_in & hready_in &
                        (htrans_in == `CPCR_HTRANS_NONSEQ);

    // configuration sequence; program low restarts from clearing
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !program_restart_n_in) begin
            state_reg   <= CPCR_ST_CLEAR;
            clr_cnt_reg <= '0;
        end else begin
            case (state_reg)
                CPCR_ST_CLEAR: begin
                    // hold init low until memory clearing ends
                    if (clr_cnt_reg == CW'(CLEAR_CYCLES - 1)) begin
                        state_reg <= CPCR_ST_WAIT;
                    end else begin
                        clr_cnt_reg <= clr_cnt_reg + 1'b1;
                    end
                end
                CPCR_ST_WAIT: begin
                    // an external low on init keeps us waiting
                    if (init_pin_in) begin
                        state_reg <= CPCR_ST_CONFIG;
                    end
                end
                CPCR_ST_CONFIG: begin
                    if (core_loaded_in) begin
                        state_reg <= CPCR_ST_STARTUP;
                    end
                end
                CPCR_ST_STARTUP: begin
                    // done held low outside postpones start-up
                    if (done_pin_in) begin
                        state_reg <= CPCR_ST_USER;
                    end
                end
                CPCR_ST_USER: begin
                    state_reg <= CPCR_ST_USER;
                end
                default: begin
                    state_reg <= CPCR_ST_CLEAR;
                end
            endcase
        end
    end

    // init and done pins: drive low or release
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            init_out      <= 1'b0;
            init_oe_n_out <= 1'b0;
            done_out      <= 1'b0;
            done_oe_n_out <= 1'b0;
        end else begin
            init_out      <= 1'b0;
            done_out      <= 1'b0;
            // init pulled low only while clearing memory
            init_oe_n_out <= !(state_reg == CPCR_ST_CLEAR);
            // done released to go high once loading is complete
            done_oe_n_out <= (state_reg == CPCR_ST_STARTUP) ||
                             (state_reg == CPCR_ST_USER);
        end
    end

    // mode pins latched on the init rising edge
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            init_q_reg   <= 1'b0;
            cfg_mode_out <= `CPCR_MODE_MASTER_SER;
        end else begin
            init_q_reg <= init_pin_in;
            if (state_reg == CPCR_ST_WAIT && init_pin_in &&
                !init_q_reg) begin
                cfg_mode_out <= mode_pins_in;
            end
        end
    end

    // pull-ups during configuration, user roles afterwards
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            mode_pullup_en_out        <= 1'b1;
            jtag_pullup_en_out        <= 1'b1;
            pll_pullup_en_out         <= 1'b1;
            mode_pins_user_out        <= 1'b0;
            jtag_pins_user_out        <= 1'b0;
            pll_clock_inputs_user_out <= 8'h00;
            bscan_enable_out          <= 1'b1;
            bscan_reset_out           <= 1'b1;
        end else begin
            mode_pullup_en_out <= (state_reg != CPCR_ST_USER);
            mode_pins_user_out <= (state_reg == CPCR_ST_USER);
            jtag_pullup_en_out <= (state_reg != CPCR_ST_USER);
            // pll pins stay tristated with pull-ups while configuring
            pll_pullup_en_out  <= (state_reg != CPCR_ST_USER);
            if (state_reg == CPCR_ST_USER) begin
                pll_clock_inputs_user_out <= ~ctrl_reg.pll_used;
            end else begin
                pll_clock_inputs_user_out <= 8'h00;
            end
            // scan inhibited and pins released when scan unused
            jtag_pins_user_out <= (state_reg == CPCR_ST_USER) &&
                                  !ctrl_reg.bscan_used;
            bscan_enable_out   <= (state_reg != CPCR_ST_USER) ||
                                  ctrl_reg.bscan_used;
            bscan_reset_out    <= !program_restart_n_in;
        end
    end

    // readback request synchroniser and falling edge detect
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rq_s1_reg <= 1'b1;
            rq_s2_reg <= 1'b1;
            rq_s3_reg <= 1'b1;
        end else begin
            rq_s1_reg <= readback_req_n_in;
            rq_s2_reg <= rq_s1_reg;
            rq_s3_reg <= rq_s2_reg;
        end
    end

    // global tristate request from the readback pin
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            global_io_tristate_out <= 1'b0;
        end else if (state_reg == CPCR_ST_USER) begin
            // after configuration only when the option keeps it
            global_io_tristate_out <= ctrl_reg.ts_after &&
                                      !rq_s2_reg;
        end else begin
            global_io_tristate_out <= !rq_s2_reg;
        end
    end

    // serial bit rate divider
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            div_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end else begin
            tick_reg <= (div_cnt_reg == DW'(BIT_DIV - 1));
            if (div_cnt_reg == DW'(BIT_DIV - 1)) begin
                div_cnt_reg <= '0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 1'b1;
            end
        end
    end

    // readback engine: one sequence per falling edge, frame zero first
    always_ff @(posedge core_clk_in) begin
        if (srst_in || state_reg != CPCR_ST_USER) begin
            rb_busy_reg       <= 1'b0;
            rb_frame_addr_out <= '0;
            bit_cnt_reg       <= 5'h00;
            shift_reg         <= 32'h0000_0000;
            word_live_reg     <= 1'b0;
        end else if (!rb_busy_reg) begin
            // a second edge while busy is ignored, no retrigger
            if (rq_fall && ctrl_reg.rb_en && !ctrl_reg.ts_after) begin
                rb_busy_reg       <= 1'b1;
                rb_frame_addr_out <= '0;
                word_live_reg     <= 1'b0;
            end
        end else if (tick_reg) begin
            if (!word_live_reg) begin
                // frame address stable since the previous tick, or since the start for frame zero
                shift_reg     <= rb_word_in;
                word_live_reg <= 1'b1;
                bit_cnt_reg   <= 5'h00;
            end else if (bit_cnt_reg == 5'h1F) begin
                word_live_reg <= 1'b0;
                if (rb_frame_addr_out == ADDR_W'(RB_WORDS - 1)) begin
                    rb_busy_reg <= 1'b0;
                end else begin
                    rb_frame_addr_out <= rb_frame_addr_out + 1'b1;
                end
            end else begin
                shift_reg   <= {shift_reg[30:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
        end
    end

    // shared serial output: readback data or test data out
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            serial_out <= 1'b0;
        end else if (rb_busy_reg && word_live_reg) begin
            serial_out <= shift_reg[31];
        end else begin
            serial_out <= tdo_in;
        end
    end

    // error flag shared with the processor port interrupt
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !program_restart_n_in) begin
            err_reg                  <= 1'b0;
            processor_port_irq_n_out <= 1'b1;
        end else begin
            // sticky until configuration restarts
            if (core_init_err_in && state_reg != CPCR_ST_USER) begin
                err_reg <= 1'b1;
            end
            if (pport_mode || ctrl_reg.pport_used) begin
                processor_port_irq_n_out <= !pport_irq_req_in;
            end else begin
                processor_port_irq_n_out <= !(err_reg ||
                                              core_init_err_in);
            end
        end
    end

    // peripheral ready, status on bit seven, master read strobe
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ready_out   <= 1'b0;
            d7_out      <= 1'b0;
            d7_oe_n_out <= 1'b1;
        end else begin
            d7_out      <= !core_busy_in;
            d7_oe_n_out <= 1'b1;
            if (state_reg == CPCR_ST_CONFIG &&
                cfg_mode_out == `CPCR_MODE_MASTER_PAR) begin
                // read strobe toward the external memory
                if (tick_reg) begin
                    ready_out <= !ready_out;
                end
            end else if (cfg_mode_out == `CPCR_MODE_ASYNC_PER &&
                         state_reg == CPCR_ST_CONFIG) begin
                ready_out <= !core_busy_in;
                // a write strobe overrides a read
                if (!periph_in.cs0_n && periph_in.cs1 &&
                    !periph_in.rd_n && periph_in.wr_n) begin
                    d7_oe_n_out <= 1'b0;
                end
            end else begin
                ready_out <= 1'b0;
            end
        end
    end

    // ahb address phase capture; zero wait states
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            addr_ph_reg   <= 1'b0;
            wr_ph_reg     <= 1'b0;
            addr_reg      <= '0;
            hreadyout_out <= 1'b0;
            hresp_out     <= `CPCR_HRESP_OKAY;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= `CPCR_HRESP_OKAY;
            addr_ph_reg   <= ahb_go;
            wr_ph_reg     <= ahb_go & hwrite_in;
            if (ahb_go) begin
                addr_reg <= haddr_in[`CPCR_ADDR_MSB:0];
            end
        end
    end

    // control register write in the data phase
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ctrl_reg <= cpcr_ctrl_t'(`CPCR_CTRL_RST);
        end else if (addr_ph_reg && wr_ph_reg &&
                     addr_reg == `CPCR_ADDR_CTRL) begin
            ctrl_reg <= cpcr_ctrl_t'(hwdata_in[`CPCR_CTRL_W-1:0]);
        end
    end

    // read data prepared in the address phase; unmapped reads zero
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (ahb_go && !hwrite_in) begin
            hrdata_out <= 32'h0000_0000;
            case (haddr_in[`CPCR_ADDR_MSB:0])
                `CPCR_ADDR_CTRL: begin
                    hrdata_out[`CPCR_CTRL_W-1:0] <= ctrl_reg;
                end
                `CPCR_ADDR_STAT: begin
                    hrdata_out[`CPCR_STAT_STATE_LSB +: 5] <= state_reg;
                    hrdata_out[`CPCR_STAT_MODE_LSB +: 4]  <= cfg_mode_out;
                    hrdata_out[`CPCR_STAT_RB_BUSY]        <= rb_busy_reg;
                    hrdata_out[`CPCR_STAT_CFG_ERR]        <= err_reg;
                    hrdata_out[`CPCR_STAT_DONE_PIN]       <= done_pin_in;
                    hrdata_out[`CPCR_STAT_ADDR_LSB +: ADDR_W] <=
                        rb_frame_addr_out;
                end
                default: begin
                    hrdata_out <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* include/cpcr_defs.svh */
// constants for the configuration pin control and readback block
`ifndef CPCR_DEFS_SVH
`define CPCR_DEFS_SVH
// register byte addresses on the ahb-lite slave
`define CPCR_ADDR_CTRL      8'h00
`define CPCR_ADDR_STAT      8'h04
`define CPCR_ADDR_MSB       7
// control register layout and reset value
`define CPCR_CTRL_RB_EN     0
`define CPCR_CTRL_TS_AFTER  1
`define CPCR_CTRL_BSCAN     2
`define CPCR_CTRL_PPORT     3
`define CPCR_CTRL_PLL_LSB   8
`define CPCR_CTRL_W         16
`define CPCR_CTRL_RST       16'h0000
// status register layout
`define CPCR_STAT_STATE_LSB 0
`define CPCR_STAT_MODE_LSB  8
`define CPCR_STAT_RB_BUSY   12
`define CPCR_STAT_CFG_ERR   13
`define CPCR_STAT_DONE_PIN  14
`define CPCR_STAT_ADDR_LSB  16
// configuration mode codes latched from the mode pins
`define CPCR_MODE_MASTER_SER 4'h0
`define CPCR_MODE_PPORT      4'h2
`define CPCR_MODE_MASTER_PAR 4'h4
`define CPCR_MODE_ASYNC_PER  4'h5
`define CPCR_MODE_SLAVE_PAR  4'h7
`define CPCR_MODE_SLAVE_SER  4'hF
// timing defaults in core clock cycles (100 MHz core clock), readback length in frames
`define CPCR_CLEAR_CYCLES   16
`define CPCR_BIT_DIV        4
`define CPCR_RB_WORDS       16
// ahb transfer type and response codes
`define CPCR_HTRANS_NONSEQ  2'h2
`define CPCR_HRESP_OKAY     1'h0
`endif

/* include/cpcr_pkg.sv */
// types shared by the configuration pin control block
package cpcr_pkg;
    // configuration sequence states, one-hot
    typedef enum logic [4:0] {
        CPCR_ST_CLEAR   = 5'h01,
        CPCR_ST_WAIT    = 5'h02,
        CPCR_ST_CONFIG  = 5'h04,
        CPCR_ST_STARTUP = 5'h08,
        CPCR_ST_USER    = 5'h10
    } cpcr_state_t;

    // bitstream options held in the control register
    typedef struct packed {
        logic [7:0] pll_used;   // per pll clock pin pair kept by a pll
        logic [3:0] spare;      // reads back as written
        logic       pport_used; // processor port in use
        logic       bscan_used; // boundary scan selected
        logic       ts_after;   // readback request keeps tristate role
        logic       rb_en;      // readback enabled
    } cpcr_ctrl_t;

    // asynchronous peripheral strobe group
    typedef struct packed {
        logic cs0_n;
        logic cs1;
        logic rd_n;
        logic wr_n;
    } cpcr_periph_t;
endpackage

/* testbench/cpcr_top_asserts.sv */
// concurrent checks on the configuration pin control block ports
`timescale 1ns/1ps
`default_nettype none
module cpcr_top_asserts (
    // clock, reset and watched pins
    input wire logic       core_clk_in,
    input wire logic       srst_in,
    input wire logic       program_restart_n_in,
    input wire logic       init_pin_in,
    input wire logic       init_oe_n_out,
    input wire logic       done_pin_in,
    input wire logic       done_oe_n_out,
    input wire logic [3:0] mode_pins_in,
    input wire logic       readback_req_n_in,
    input wire logic       core_busy_in,
    input wire logic       core_init_err_in,
    input wire logic       processor_port_irq_n_out,
    input wire logic       global_io_tristate_out,
    input wire logic       bscan_enable_out,
    input wire logic       bscan_reset_out,
    input wire logic       mode_pins_user_out,
    input wire logic       jtag_pins_user_out,
    input wire logic       ready_out,
    input wire logic [3:0] cfg_mode_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // four low samples cover the two-flop sync plus the output flop
    tristate_cfg_a: assert property (
        (init_oe_n_out && !done_oe_n_out && !readback_req_n_in) [*4]
        |-> global_io_tristate_out) else $error("no tristate in config");
    jtag_user_a: assert property (
        jtag_pins_user_out |-> !bscan_enable_out)
        else $error("scan still enabled with test pins released");
    init_pull_a: assert property (
        $fell(srst_in) |-> !init_oe_n_out [*3])
        else $error("init not held low while clearing");
    done_hold_a: assert property (
        done_oe_n_out && !done_pin_in |=> !mode_pins_user_out)
        else $error("start-up while done held low");
    prog_scan_a: assert property (
        !program_restart_n_in |-> ##[1:3] bscan_reset_out)
        else $error("scan not reset by program restart");
    cfg_err_a: assert property (
        core_init_err_in && init_oe_n_out && !done_oe_n_out
        && cfg_mode_out != 4'h2 |-> ##[1:3] !processor_port_irq_n_out)
        else $error("error flag not driven low");
    // ready lags busy by one flop, so three busy samples suffice
    ready_busy_a: assert property (
        (cfg_mode_out == 4'h5 && !done_oe_n_out) throughout
        core_busy_in [*3] |-> !ready_out) else $error("ready while busy");
    mode_latch_a: assert property (
        $rose(init_pin_in) && init_oe_n_out
        |-> ##[1:3] cfg_mode_out == mode_pins_in)
        else $error("mode not latched on init rise");
    // main scenarios reached
    cover property (mode_pins_user_out && $fell(readback_req_n_in));
    cover property (!program_restart_n_in);
    cover property ($rose(done_pin_in));
endmodule
bind cpcr_top cpcr_top_asserts chk (.*);
`default_nettype wire

/* testbench/cpcr_host_model.sv */
// configuration host: open-drain wires and frame store
`timescale 1ns/1ps
`default_nettype none
module cpcr_host_model (
    // device open-drain enables and host holds
    input  wire logic        init_oe_n_in,
    input  wire logic        done_oe_n_in,
    input  wire logic        init_hold_in,
    input  wire logic        done_hold_in,
    // frame store access
    input  wire logic [15:0] frame_addr_in,
    output logic             init_pin_out,
    output logic             done_pin_out,
    output logic [31:0]      frame_word_out
);
    // pulled-up wires, low if either party pulls
    assign init_pin_out = init_oe_n_in & ~init_hold_in;
    assign done_pin_out = done_oe_n_in & ~done_hold_in;
    // each frame word carries its own frame number
    assign frame_word_out = {16'hA5C3, frame_addr_in};
endmodule
`default_nettype wire

/* testbench/cpcr_top_tb.sv */
// self-checking bench for the configuration pin control block
`timescale 1ns/1ps
`default_nettype none
module cpcr_top_tb;
    import cpcr_pkg::*;
    localparam int BD = 2; // serial bit time, kept short
    logic core_clk_in = 0, srst_in = 1, hsel_in = 0, hwrite_in = 0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rb_word_in;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2;
    logic hready_in, hreadyout_out, hresp_out, init_pin_in, init_out;
    logic program_restart_n_in = 1, init_oe_n_out, done_pin_in, done_out;
    logic done_oe_n_out, init_hold = 1, done_hold = 1, tdo_in = 0;
    logic readback_req_n_in = 1, serial_out, ready_out, d7_out, d7_oe_n_out;
    logic core_loaded_in = 0, core_busy_in = 0, core_init_err_in = 0;
    logic pport_irq_req_in = 0, processor_port_irq_n_out, bscan_reset_out;
    logic global_io_tristate_out, bscan_enable_out, mode_pullup_en_out;
    logic jtag_pullup_en_out, pll_pullup_en_out, mode_pins_user_out;
    logic jtag_pins_user_out;
    logic [15:0] rb_frame_addr_out;
    logic [7:0] pll_clock_inputs_user_out;
    logic [3:0] mode_pins_in = 4'h5, cfg_mode_out;
    cpcr_periph_t periph_in = 4'hB; // deselected, no strobes
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    // one slave, so its ready is the bus ready
    assign hready_in = hreadyout_out;
    cpcr_top #(.CLEAR_CYCLES(4), .BIT_DIV(BD), .RB_WORDS(2)) dut (.*);
    cpcr_host_model host (.init_oe_n_in(init_oe_n_out),
        .done_oe_n_in(done_oe_n_out), .init_hold_in(init_hold),
        .done_hold_in(done_hold), .frame_addr_in(rb_frame_addr_out),
        .init_pin_out(init_pin_in), .done_pin_out(done_pin_in),
        .frame_word_out(rb_word_in));
    always #5 core_clk_in = ~core_clk_in;
    // hang guard
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // single word transfer; data taken at the data-phase ready edge
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        hsel_in <= 1;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= {24'h0, a};
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        hsel_in <= 0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        r = hrdata_out;
    endtask
    task automatic t_config;
        tick(6);
        chk("pullups", 3'b111, {mode_pullup_en_out, jtag_pullup_en_out,
            pll_pullup_en_out});
        init_hold <= 0; // request still high
        tick(4);
        chk("cfg_mode", 4'h5, cfg_mode_out);
        readback_req_n_in <= 0;
        tick(5);
        chk("tristate", 1, global_io_tristate_out);
        readback_req_n_in <= 1;
        core_busy_in <= 1;
        tick(4);
        chk("ready_busy", 0, ready_out);
        core_busy_in <= 0;
        periph_in <= 4'h5; // selected read
        tick(4);
        chk("d7", 3'b101, {ready_out, d7_oe_n_out, d7_out});
        periph_in <= 4'hB;
        core_init_err_in <= 1;
        tick(1);
        core_init_err_in <= 0;
        core_loaded_in <= 1;
        tick(6);
        chk("err", 2'b00, {processor_port_irq_n_out,
            mode_pins_user_out});
        done_hold <= 0;
        tick(6);
        chk("user", 3'b110, {mode_pins_user_out, jtag_pins_user_out,
            bscan_enable_out});
        chk("pll_user", 8'hFF, pll_clock_inputs_user_out);
    endtask
    task automatic t_readback;
        logic [31:0] w;
        ahb(8'h08, 1, 32'hFFFFFFFF, w);
        ahb(8'h08, 0, 32'h0, w);
        chk("unmapped", 32'h0, w);
        ahb(8'h00, 1, 32'h1, w);
        ahb(8'h00, 0, 32'h0, w);
        chk("ctrl", 32'h1, w);
        readback_req_n_in <= 0;
        tick(5);
        chk("frame0", 16'h0, rb_frame_addr_out);
        do tick(1); while (serial_out !== 1'b1);
        for (int i = 31; i >= 0; i--) begin
            w[i] = serial_out;
            tick(BD);
        end
        chk("word0", 32'hA5C30000, w);
        tick(200);
        chk("one_pass", 16'h1, rb_frame_addr_out);
        readback_req_n_in <= 1;
        ahb(8'h00, 1, 32'hA, w);
        readback_req_n_in <= 0;
        tick(5);
        chk("ts_after", 2'b11, {global_io_tristate_out,
            processor_port_irq_n_out});
        readback_req_n_in <= 1;
        program_restart_n_in <= 0;
        tick(1);
        program_restart_n_in <= 1;
        tick(2);
        chk("restart", 2'b01, {init_oe_n_out,
            processor_port_irq_n_out});
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(2);
        srst_in <= 0;
        t_config();
        t_readback();
        end_sim();
    end
endmodule
`default_nettype wire
